// [rtl/ext_bus_defs.svh]
// Register offsets, reset values and field positions of the bus-port block.
// Assumes inclusion by the design module only.
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_UPPER_DATA   8'h00
`define IDX_LOWER_DATA   8'h01
`define IDX_UPPER_DIR    8'h02
`define IDX_LOWER_DIR    8'h03
`define IDX_CTRL_DATA    8'h08
`define IDX_CTRL_DIR     8'h09
`define IDX_ASSIGN       8'h0a
`define IDX_PULLUP       8'h0c
`define IDX_MODE_CFG     8'h0b
`define IDX_MISC         8'h13
`define IDX_ACCESS       8'h20
`define IDX_STATUS       8'h21
`define EXP_REG_COUNT    8'h10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_PORT_DIR     8'h00
`define RST_PORT_DATA    8'h00
`define RST_ASSIGN       8'h00
`define RST_MODE_CFG     8'h00
`define RST_MISC         8'h00
`define RST_PULLUP       8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MODE_LSB         0
`define MODE_MSB         1
`define EME_BIT          2
`define NARROW_FOLLOWING_BUS_BIT         6
`define PUPE_BIT         4
`define ASG_BYTE_LANE_STROBE_N_BIT    3
`define ASG_RDW_BIT      2
`define ASG_DBE_BIT      7
`define INT_PINS_MASK    8'h03

`endif

// [rtl/ext_bus_pkg.sv]
// Types shared by the bus-port block.
// Assumes the constants header sits beside it.
package ext_bus_pkg;
    typedef enum logic [3:0] {
        MODE_SINGLE = 4'h1,
        MODE_WIDE   = 4'h2,
        MODE_NARROW = 4'h4,
        MODE_PERIPH = 4'h8
    } op_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ADDR = 3'h2,
        ST_DATA = 3'h4
    } ext_state_t;
endpackage : ext_bus_pkg

// [rtl/external_bus_port_control.sv]
// External multiplexed bus and shared general-purpose port control.
// Assumes an AHB-Lite master on hclk and external pins seen via 4 flops.
`timescale 1ns/100ps
`include "ext_bus_defs.svh"

module external_bus_port_control (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  clk_en,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Operating mode
    input  wire ext_bus_pkg::op_mode_t op_mode,
    // Internal access request for the external bus
    input  wire logic                  acc_req,
    input  wire logic [15:0]           acc_addr,
    input  wire logic                  acc_read,
    input  wire logic                  acc_byte,
    input  wire logic                  acc_ram,
    input  wire logic                  acc_regfollow,
    input  wire logic [15:0]           acc_wdata,
    output logic                       acc_done,
    output logic      [15:0]           acc_rdata,
    // Upper port pins
    input  wire logic [7:0]            upper_port_pins_in,
    output logic      [7:0]            upper_port_pins_out,
    output logic      [7:0]            upper_port_pins_oe,
    // Lower port pins
    input  wire logic [7:0]            lower_port_pins_in,
    output logic      [7:0]            lower_port_pins_out,
    output logic      [7:0]            lower_port_pins_oe,
    // Control port pins
    input  wire logic [7:0]            ctrl_port_pins_in,
    output logic      [7:0]            ctrl_port_pins_out,
    output logic      [7:0]            ctrl_port_pins_oe,
    output logic      [7:0]            ctrl_port_pullup,
    // Bus control outputs
    output logic                       byte_lane_strobe_n,
    output logic                       addr_bit0,
    output logic                       read_not_write,
    output logic                       data_bus_enable_n,
    output logic                       bus_narrow
);
    import ext_bus_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [23:0] sync1_ff;
    logic [23:0] sync2_ff;
    logic [23:0] sync3_ff;
    logic [23:0] pins_ff;
    logic [23:0] raw_pins;

    assign raw_pins = {ctrl_port_pins_in, lower_port_pins_in,
                       upper_port_pins_in};

    // A pin change counts once the second and third stages agree.
    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                    sync3_ff[gi] <= 1'b0;
                    pins_ff[gi]  <= 1'b0;
                end else if (clk_en) begin
                    sync1_ff[gi] <= raw_pins[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    sync3_ff[gi] <= sync2_ff[gi];
                    if (sync2_ff[gi] == sync3_ff[gi]) begin
                        pins_ff[gi] <= sync3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic expanded;
    logic periph;
    logic bus_pins;

    assign expanded = (op_mode == MODE_WIDE) || (op_mode == MODE_NARROW);
    assign periph   = (op_mode == MODE_PERIPH);
    assign bus_pins = expanded || periph;

    // ------------------------------------------------------------------
    // AHB-Lite address phase capture
    // ------------------------------------------------------------------
    logic       wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic       start;
    logic [7:0] idx;

    assign start     = hsel && hready && htrans[1];
    assign idx       = haddr[9:2];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= 8'h00;
        end else if (clk_en) begin
            wr_pend_ff <= start && hwrite;
            wr_idx_ff  <= idx;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] upper_port_data_ff;
    logic [7:0] lower_port_data_ff;
    logic [7:0] upper_port_direction_ff;
    logic [7:0] lower_port_direction_ff;
    logic [7:0] control_port_data_ff;
    logic [7:0] control_port_direction_ff;
    logic [7:0] control_pin_assignment_ff;
    logic [7:0] pullup_ctrl_ff;
    logic [7:0] mode_cfg_ff;
    logic [7:0] misc_ff;
    logic       upper_map;
    logic       lower_map;
    logic       ctrl_map;
    logic       exp_map;
    logic [7:0] wd;

    assign wd        = hwdata[7:0];
    assign exp_map   = !(periph && (wr_idx_ff < `EXP_REG_COUNT));
    assign upper_map = !bus_pins;
    assign lower_map = !bus_pins;
    assign ctrl_map  = !periph &&
                       !(expanded && mode_cfg_ff[`EME_BIT]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upper_port_data_ff        <= `RST_PORT_DATA;
            lower_port_data_ff        <= `RST_PORT_DATA;
            upper_port_direction_ff   <= `RST_PORT_DIR;
            lower_port_direction_ff   <= `RST_PORT_DIR;
            control_port_data_ff      <= `RST_PORT_DATA;
            control_port_direction_ff <= `RST_PORT_DIR;
            control_pin_assignment_ff <= `RST_ASSIGN;
            pullup_ctrl_ff            <= `RST_PULLUP;
            mode_cfg_ff               <= `RST_MODE_CFG;
            misc_ff                   <= `RST_MISC;
        end else if (clk_en && wr_pend_ff) begin
            case (wr_idx_ff)
                `IDX_UPPER_DATA: begin
                    if (upper_map && exp_map) begin
                        upper_port_data_ff <= wd;
                    end
                end
                `IDX_LOWER_DATA: begin
                    if (lower_map && exp_map) begin
                        lower_port_data_ff <= wd;
                    end
                end
                `IDX_UPPER_DIR: begin
                    if (upper_map && exp_map) begin
                        upper_port_direction_ff <= wd;
                    end
                end
                `IDX_LOWER_DIR: begin
                    if (lower_map && exp_map) begin
                        lower_port_direction_ff <= wd;
                    end
                end
                `IDX_CTRL_DATA: begin
                    if (ctrl_map) begin
                        control_port_data_ff <= wd;
                    end
                end
                `IDX_CTRL_DIR: begin
                    if (ctrl_map) begin
                        control_port_direction_ff <= wd;
                    end
                end
                `IDX_ASSIGN: begin
                    if (exp_map) begin
                        control_pin_assignment_ff <= wd;
                    end
                end
                `IDX_PULLUP: begin
                    if (exp_map) begin
                        pullup_ctrl_ff <= wd;
                    end
                end
                `IDX_MODE_CFG: begin
                    if (exp_map) begin
                        mode_cfg_ff <= wd;
                    end
                end
                `IDX_MISC: begin
                    misc_ff <= wd;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // External access engine
    // ------------------------------------------------------------------
    ext_state_t  state_ff;
    ext_state_t  nxt_state;
    logic        strobe_ff;
    logic        a0_ff;
    logic        rw_ff;
    logic        narrow_ff;
    logic [15:0] addr_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rdata_ff;
    logic        done_ff;
    logic        nxt_narrow;
    logic        swap;
    logic        take;

    // A request stands until done is seen, so the done cycle takes none.
    assign take       = (state_ff == ST_IDLE) && acc_req && bus_pins &&
                        !done_ff;

    // Narrow width in narrow mode, or the following region in wide mode when selected.
    assign nxt_narrow = (op_mode == MODE_NARROW) ||
                        ((op_mode == MODE_WIDE) && acc_regfollow &&
                         misc_ff[`NARROW_FOLLOWING_BUS_BIT]);
    assign swap       = !acc_byte && acc_addr[0] && acc_ram;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_state = ST_ADDR;
                end
            end
            ST_ADDR: nxt_state = ST_DATA;
            ST_DATA: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_IDLE;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strobe_ff <= 1'b1;
            a0_ff     <= 1'b0;
            rw_ff     <= 1'b1;
            narrow_ff <= 1'b0;
            addr_ff   <= 16'h0000;
            wdata_ff  <= 16'h0000;
        end else if (clk_en && take) begin
            addr_ff   <= acc_addr;
            rw_ff     <= acc_read;
            narrow_ff <= nxt_narrow;
            if (acc_byte) begin
                strobe_ff <= !acc_addr[0];
                a0_ff     <= acc_addr[0];
                wdata_ff  <= {acc_wdata[7:0], acc_wdata[7:0]};
            end else if (swap) begin
                strobe_ff <= 1'b1;
                a0_ff     <= 1'b1;
                wdata_ff  <= {acc_wdata[7:0], acc_wdata[15:8]};
            end else begin
                strobe_ff <= 1'b0;
                a0_ff     <= 1'b0;
                wdata_ff  <= acc_wdata;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 16'h0000;
            done_ff  <= 1'b0;
        end else if (clk_en) begin
            done_ff <= (state_ff == ST_DATA);
            if (state_ff == ST_DATA) begin
                if (narrow_ff) begin
                    rdata_ff <= {8'h00, pins_ff[7:0]};
                end else if (a0_ff && strobe_ff) begin
                    rdata_ff <= {pins_ff[15:8], pins_ff[7:0]};
                end else begin
                    rdata_ff <= {pins_ff[7:0], pins_ff[15:8]};
                end
            end
        end
    end

    assign acc_done           = done_ff;
    assign acc_rdata          = rdata_ff;
    assign byte_lane_strobe_n = strobe_ff;
    assign addr_bit0          = a0_ff;
    assign read_not_write     = rw_ff;
    assign bus_narrow         = narrow_ff;
    assign data_bus_enable_n  = !(state_ff == ST_DATA);

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    logic drive_data;

    assign drive_data = (state_ff == ST_DATA) && !rw_ff;

    always_comb begin
        if (!bus_pins) begin
            upper_port_pins_out = upper_port_data_ff;
            upper_port_pins_oe  = upper_port_direction_ff;
            lower_port_pins_out = lower_port_data_ff;
            lower_port_pins_oe  = lower_port_direction_ff;
        end else if (state_ff == ST_ADDR) begin
            upper_port_pins_out = addr_ff[15:8];
            upper_port_pins_oe  = 8'hff;
            lower_port_pins_out = addr_ff[7:0];
            lower_port_pins_oe  = 8'hff;
        end else if (narrow_ff) begin
            upper_port_pins_out = a0_ff ? wdata_ff[15:8]
                                        : wdata_ff[7:0];
            upper_port_pins_oe  = {8{drive_data}};
            lower_port_pins_out = addr_ff[7:0];
            lower_port_pins_oe  = 8'hff;
        end else begin
            upper_port_pins_out = wdata_ff[15:8];
            upper_port_pins_oe  = {8{drive_data}};
            lower_port_pins_out = wdata_ff[7:0];
            lower_port_pins_oe  = {8{drive_data}};
        end
    end

    // Control port: bus roles override direction, interrupt pins input only.
    logic [7:0] role_sel;
    logic [7:0] role_val;

    assign role_sel = expanded ?
        (control_pin_assignment_ff & 8'h8c) : 8'h00;
    assign role_val = {data_bus_enable_n, 3'h0, byte_lane_strobe_n,
                       read_not_write, 2'h0};

    generate
        for (gi = 0; gi < 8; gi++) begin : g_ctrl
            always_comb begin
                if (gi < 2) begin
                    ctrl_port_pins_oe[gi]  = 1'b0;
                    ctrl_port_pins_out[gi] = 1'b0;
                end else if (role_sel[gi]) begin
                    ctrl_port_pins_oe[gi]  = 1'b1;
                    ctrl_port_pins_out[gi] = role_val[gi];
                end else begin
                    ctrl_port_pins_oe[gi]  =
                        control_port_direction_ff[gi];
                    ctrl_port_pins_out[gi] = control_port_data_ff[gi];
                end
                ctrl_port_pullup[gi] = pullup_ctrl_ff[`PUPE_BIT] &&
                    (gi == 0 || gi == 1 || gi == 2 || gi == 3 || gi == 7) &&
                    !ctrl_port_pins_oe[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && start && !hwrite) begin
            hrdata <= {24'h000000, rd_byte};
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            `IDX_UPPER_DATA: rd_byte = upper_map ? ((upper_port_direction_ff
                & upper_port_data_ff) | (~upper_port_direction_ff
                & pins_ff[7:0])) : 8'h00;
            `IDX_LOWER_DATA: rd_byte = lower_map ? ((lower_port_direction_ff
                & lower_port_data_ff) | (~lower_port_direction_ff
                & pins_ff[15:8])) : 8'h00;
            `IDX_UPPER_DIR:  rd_byte = upper_map ? upper_port_direction_ff
                                                 : 8'h00;
            `IDX_LOWER_DIR:  rd_byte = lower_map ? lower_port_direction_ff
                                                 : 8'h00;
            `IDX_CTRL_DATA:  rd_byte = ctrl_map ? ((ctrl_port_pins_oe
                & control_port_data_ff) | (~ctrl_port_pins_oe
                & pins_ff[23:16])) : 8'h00;
            `IDX_CTRL_DIR:   rd_byte = ctrl_map ? control_port_direction_ff
                                                : 8'h00;
            `IDX_ASSIGN:     rd_byte = periph ? 8'h00
                                              : control_pin_assignment_ff;
            `IDX_PULLUP:     rd_byte = periph ? 8'h00 : pullup_ctrl_ff;
            `IDX_MODE_CFG:   rd_byte = periph ? 8'h00 : mode_cfg_ff;
            `IDX_MISC:       rd_byte = misc_ff;
            `IDX_STATUS:     rd_byte = {5'h00, narrow_ff, state_ff != ST_IDLE,
                                        bus_pins};
            default:         rd_byte = 8'h00;
        endcase
    end
endmodule : external_bus_port_control

// [verif/ext_bus_chk.sv]
// Checker for the bus-port block, bound onto its top ports.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
module ext_bus_chk (
    // Watched ports
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire ext_bus_pkg::op_mode_t op_mode,
    input wire logic                  acc_req,
    input wire logic [15:0]           acc_addr,
    input wire logic                  acc_read,
    input wire logic                  acc_byte,
    input wire logic                  acc_ram,
    input wire logic                  acc_done,
    input wire logic                  byte_lane_strobe_n,
    input wire logic                  addr_bit0,
    input wire logic                  read_not_write
);
    import ext_bus_pkg::*;
    // ----------------------------------------------------------------
    // Bus cycle checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_done_late: assert property (
        $rose(acc_req) && op_mode != MODE_SINGLE |-> ##3 acc_done)
        else $error("external cycle done late");
    chk_single_idle: assert property (
        op_mode == MODE_SINGLE |-> !acc_done)
        else $error("external cycle in single chip");
    chk_byte_even: assert property (
        acc_done && acc_byte && !acc_addr[0]
        |-> byte_lane_strobe_n && !addr_bit0)
        else $error("bad even byte strobe");
    chk_byte_odd: assert property (
        acc_done && acc_byte && acc_addr[0]
        |-> !byte_lane_strobe_n && addr_bit0)
        else $error("bad odd byte strobe");
    chk_half_even: assert property (
        acc_done && !acc_byte && !acc_addr[0]
        |-> !byte_lane_strobe_n && !addr_bit0)
        else $error("bad aligned halfword strobe");
    chk_half_odd: assert property (
        acc_done && !acc_byte && acc_ram && acc_addr[0]
        |-> byte_lane_strobe_n && addr_bit0)
        else $error("bad misaligned strobe");
    chk_both_ram: assert property (
        acc_done && byte_lane_strobe_n && addr_bit0 |-> acc_ram && !acc_byte)
        else $error("both high off internal RAM");
    chk_rw_dir: assert property (
        acc_done |-> read_not_write == acc_read)
        else $error("bad read write level");
endmodule : ext_bus_chk

// [verif/ext_bus_mem.sv]
// External memory model on the multiplexed bus pins.
// Assumes upper pins carry the high byte and lower pins the low byte.
`timescale 1ns/100ps
module ext_bus_mem (
    // Bus side
    input  wire logic        hclk,
    input  wire logic        data_bus_enable_n,
    input  wire logic        read_not_write,
    input  wire logic [7:0]  upper_port_pins_out,
    input  wire logic [7:0]  lower_port_pins_out,
    output logic      [7:0]  upper_port_pins_in,
    output logic      [7:0]  lower_port_pins_in,
    output logic      [15:0] wr_seen_ff
);
    // ----------------------------------------------------------------
    // Capture writes; the read word stands steady on the pin inputs.
    // ----------------------------------------------------------------
    assign upper_port_pins_in = 8'hc3;
    assign lower_port_pins_in = 8'h5a;
    initial begin
        wr_seen_ff = '0;
    end
    always @(posedge hclk) begin
        if (!data_bus_enable_n && !read_not_write) begin
            wr_seen_ff <= {upper_port_pins_out,
                           lower_port_pins_out};
        end
    end
endmodule : ext_bus_mem

// [verif/tb_external_bus_port_control.sv]
// Self-checking bench for the bus-port block with an external memory.
// Assumes the checker and the memory model are compiled before it.
`timescale 1ns/100ps
module tb_external_bus_port_control;
    import ext_bus_pkg::*;
    logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    op_mode_t    op_mode;
    logic        acc_req, acc_read, acc_byte, acc_ram, acc_regfollow, acc_done;
    logic [15:0] acc_addr, acc_wdata, acc_rdata, wr_seen_ff;
    logic [7:0]  upper_port_pins_in, upper_port_pins_out, upper_port_pins_oe;
    logic [7:0]  lower_port_pins_in, lower_port_pins_out, lower_port_pins_oe;
    logic [7:0]  ctrl_port_pins_in, ctrl_port_pins_out, ctrl_port_pins_oe;
    logic [7:0]  ctrl_port_pullup;
    logic        byte_lane_strobe_n, addr_bit0, read_not_write;
    logic        data_bus_enable_n, bus_narrow;
    int          num_errors, cmp_count;
    external_bus_port_control external_bus_port_control_i (
        .hready (hreadyout),
        .*
    );
    ext_bus_mem ext_bus_mem_i (.*);
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [7:0] a, d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer
    task automatic rc(input logic [7:0] a, e);
        xfer(1'b0, a, 8'h00);
        check(rd, {24'h0, e});
    endtask : rc
    task automatic ext(input logic [15:0] a, input logic r, b, m,
                       input logic [15:0] wd);
        @(posedge hclk);
        {acc_req, acc_addr, acc_read, acc_byte, acc_ram} <= {1'b1, a, r, b, m};
        acc_wdata <= wd;
        repeat (20) if (acc_done !== 1'b1) @(posedge hclk);
        check({31'h0, acc_done}, 32'h1);
        acc_req <= 1'b0;
    endtask : ext
    task automatic final_report;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // ----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial begin
        #200000;
        num_errors++;
        final_report;
    end
    initial begin
        {hresetn, hsel, htrans, hwrite, haddr, hwdata} = '0;
        {acc_req, acc_read, acc_byte, acc_ram, acc_regfollow} = '0;
        {acc_addr, acc_wdata, ctrl_port_pins_in} = '0;
        {clk_en, hsize, op_mode} = {1'b1, 3'h2, MODE_SINGLE};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(upper_port_pins_oe | lower_port_pins_oe, 0);
        check(ctrl_port_pullup, 8'h8f);
        check({31'h0, hresp}, 32'h0);
        rc(8'h08, 8'h00);
        rc(8'h0c, 8'h00);
        xfer(1'b1, 8'h08, 8'ha5);
        xfer(1'b1, 8'h0c, 8'h5a);
        xfer(1'b1, 8'h04, 8'h3c);
        xfer(1'b1, 8'h24, 8'h0c);
        rc(8'h04, 8'h18);
        check(upper_port_pins_oe, 8'ha5);
        check(lower_port_pins_oe, 8'h5a);
        check(lower_port_pins_out, 8'h3c);
        rc(8'h24, 8'h0c);
        check(ctrl_port_pullup, 8'h83);
        rc(8'hc0, 8'h00);
        @(posedge hclk) op_mode <= MODE_WIDE;
        rc(8'h04, 8'h00);
        rc(8'h08, 8'h00);
        xfer(1'b1, 8'h2c, 8'h04);
        rc(8'h24, 8'h00);
        xfer(1'b1, 8'h2c, 8'h00);
        rc(8'h24, 8'h0c);
        xfer(1'b1, 8'h28, 8'h80);
        rc(8'h28, 8'h80);
        check(ctrl_port_pins_oe, 8'h8c);
        check(ctrl_port_pins_out, 8'h80);
        check(ctrl_port_pullup, 8'h03);
        ext(16'h1000, 1'b0, 1'b0, 1'b0, 16'h1234);
        check(wr_seen_ff, 16'h1234);
        check(bus_narrow, 1'b0);
        ext(16'h0801, 1'b0, 1'b0, 1'b1, 16'h1234);
        check(wr_seen_ff, 16'h3412);
        ext(16'h1002, 1'b1, 1'b1, 1'b0, 16'h0000);
        check(acc_rdata, 16'hc35a);
        ext(16'h0801, 1'b1, 1'b0, 1'b1, 16'h0000);
        check(acc_rdata, 16'h5ac3);
        ext(16'h1003, 1'b0, 1'b1, 1'b0, 16'h00aa);
        xfer(1'b1, 8'h4c, 8'h40);
        acc_regfollow <= 1'b1;
        ext(16'h0204, 1'b1, 1'b1, 1'b0, 16'h0000);
        check(acc_rdata, 16'h00c3);
        check(bus_narrow, 1'b1);
        acc_regfollow <= 1'b0;
        @(posedge hclk) op_mode <= MODE_NARROW;
        ext(16'h1004, 1'b0, 1'b1, 1'b0, 16'h0077);
        check(wr_seen_ff, 16'h7704);
        @(posedge hclk) op_mode <= MODE_PERIPH;
        rc(8'h24, 8'h00);
        final_report;
    end
endmodule : tb_external_bus_port_control
bind external_bus_port_control ext_bus_chk ext_bus_chk_i (.*);
